/* include/igc_pkg.sv */
// Constants for the control, flush and general-call block of the serial bus node.
// Assumes a 25 MHz system clock and a 32-bit Avalon-MM register bus.
package igc_pkg;

    // Register byte offsets
    localparam logic [3:0]  IGC_OFS_CTRL    = 4'h0;
    localparam logic [3:0]  IGC_OFS_STATUS  = 4'h4;
    localparam logic [3:0]  IGC_OFS_IRQ_ST  = 4'h8;
    localparam logic [3:0]  IGC_OFS_IRQ_MSK = 4'hC;
    localparam int          IGC_ADDR_W      = 4;

    // Control word fields
    localparam int          IGC_SPEED_LSB   = 4;
    localparam int          IGC_SPEED_MSB   = 5;
    localparam int          IGC_GCM_BIT     = 6;
    localparam int          IGC_TXF_BIT     = 7;
    localparam int          IGC_RXF_BIT     = 8;
    localparam int          IGC_DMATX_BIT   = 9;
    localparam logic [1:0]  IGC_SPEED_STD   = 2'h0;
    localparam logic [1:0]  IGC_SPEED_FAST  = 2'h1;
    localparam logic [1:0]  IGC_SPEED_RST   = 2'h0;
    localparam logic        IGC_GCM_RST     = 1'b0;
    localparam logic        IGC_DMATX_RST   = 1'b0;

    // Flush path indices
    localparam int          IGC_PATH_TX     = 0;
    localparam int          IGC_PATH_RX     = 1;
    localparam int          IGC_NPATH       = 2;

    // Interrupt status / mask layout
    localparam int          IGC_IRQ_W       = 4;
    localparam int          IGC_IRQ_TXF     = 0;
    localparam int          IGC_IRQ_RXF     = 1;
    localparam int          IGC_IRQ_GCALL   = 2;
    localparam int          IGC_IRQ_DMATX   = 3;
    localparam logic [3:0]  IGC_IRQ_RST     = 4'h0;
    localparam logic [7:0]  IGC_STATUS_RST  = 8'h00;

    // Timing
    localparam int          IGC_CLK_MHZ     = 25;
    localparam int          IGC_BIT_NS_STD  = 10000;
    localparam int          IGC_BIT_NS_FAST = 2500;
    localparam int          IGC_BIT_CYC_STD  = (IGC_BIT_NS_STD * IGC_CLK_MHZ + 999) / 1000;
    localparam int          IGC_BIT_CYC_FAST = (IGC_BIT_NS_FAST * IGC_CLK_MHZ + 999) / 1000;
    localparam int          IGC_DIV_W       = 8;
    localparam logic [7:0]  IGC_DIV_STD_LAST  = 8'(IGC_BIT_CYC_STD - 1);
    localparam logic [7:0]  IGC_DIV_FAST_LAST = 8'(IGC_BIT_CYC_FAST - 1);

    // Flush completion: link clock edges seen, or a fallback if the link clock stands still
    localparam int          IGC_CNT_W       = 7;
    localparam logic [6:0]  IGC_FL_EDGES_LAST = 7'h01;
    localparam logic [6:0]  IGC_FL_TMO_LAST   = 7'h3F;

endpackage : igc_pkg

/* logic/igc_ctrl.sv */
// Control register, flush sequencing, general-call routing and DMA TX enable of the node.
// Assumes same-clock FIFO/engine logic on the rx and dma inputs; the link clock is asynchronous.
//
// Chosen here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module igc_ctrl (
    input  wire logic                        clk_i,          // System clock, 25 MHz
    input  wire logic                        rst_i,          // Synchronous reset, active high
    input  wire logic [igc_pkg::IGC_ADDR_W-1:0] avs_address_i, // Byte address
    input  wire logic                        avs_read_i,     // Read request
    input  wire logic                        avs_write_i,    // Write request
    input  wire logic [31:0]                 avs_writedata_i, // Write data
    input  wire logic [3:0]                  avs_byteenable_i, // Byte lanes
    output logic      [31:0]                 avs_readdata_o, // Read data
    output logic                             avs_waitrequest_o, // Stall
    output logic                             irq_o,          // Level interrupt
    input  wire logic                        i2c_clk_i,      // Link clock, asynchronous
    output logic                             bit_tick_o,     // One pulse per bit period
    output logic [1:0]                       bus_speed_select_o, // Speed code
    output logic                             fast_mode_o,    // Fast mode selected
    output logic                             transmit_flush_o, // Tx FIFO/fsm flush level
    output logic                             receive_flush_o, // Rx FIFO/fsm flush level
    input  wire logic                        rx_valid_i,     // Received byte strobe
    input  wire logic [7:0]                  rx_byte_i,      // Received byte
    input  wire logic                        rx_gcall_i,     // Byte belongs to a general call
    input  wire logic                        rx_gcall_hw_i,  // General call is a hardware one
    output logic                             rx_push_o,      // Push into receive FIFO
    output logic [7:0]                       rx_data_o,      // Data for receive FIFO
    output logic                             gcall_action_o, // Direct general call action
    output logic [7:0]                       gcall_code_o,   // Status code word
    input  wire logic                        tx_space_i,     // Tx FIFO can take a word
    input  wire logic                        dma_eot_i,      // DMA end of transfer
    output logic                             dma_tx_run_o,   // DMA TX interface running
    output logic                             dma_tx_req_o    // DMA TX request
);
    import igc_pkg::*;

    // Bus slave: one wait cycle, then the access completes
    logic                 wait_q;
    logic [31:0]          rdata_q;
    logic                 acc_go;
    logic                 wr_go;
    logic                 rd_take;
    logic [31:0]          wmask;
    logic                 sel_ctrl;
    logic                 sel_stat;
    logic                 sel_irqs;
    logic                 sel_mask;

    assign acc_go   = (avs_read_i | avs_write_i) & wait_q;
    assign wr_go    = avs_write_i & ~wait_q;
    assign rd_take  = avs_read_i & wait_q;
    assign wmask    = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                       {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
    assign sel_ctrl = (avs_address_i == IGC_OFS_CTRL);
    assign sel_stat = (avs_address_i == IGC_OFS_STATUS);
    assign sel_irqs = (avs_address_i == IGC_OFS_IRQ_ST);
    assign sel_mask = (avs_address_i == IGC_OFS_IRQ_MSK);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= ~acc_go;
        end
    end

    // Control register fields
    logic [1:0]           speed_q;
    logic                 gcm_q;
    logic                 dmatx_q;
    logic [1:0]           busy;
    logic [1:0]           flush_done;
    logic [31:0]          ctrl_rd;
    logic [31:0]          ctrl_wd;
    logic                 wr_ctrl;
    logic [1:0]           speed_d;
    logic                 gcm_d;
    logic                 dmatx_d;
    logic [1:0]           flush_start;

    assign ctrl_rd = {22'h000000, dmatx_q, busy[IGC_PATH_RX], busy[IGC_PATH_TX],
                      gcm_q, speed_q, 4'h0};
    assign ctrl_wd = (avs_writedata_i & wmask) | (ctrl_rd & ~wmask);
    assign wr_ctrl = wr_go & sel_ctrl;
    assign speed_d = wr_ctrl ? ctrl_wd[IGC_SPEED_MSB:IGC_SPEED_LSB] : speed_q;
    assign gcm_d   = wr_ctrl ? ctrl_wd[IGC_GCM_BIT] : gcm_q;
    // Software setting the enable wins over an end of transfer in the same cycle
    assign dmatx_d = wr_ctrl ? ctrl_wd[IGC_DMATX_BIT] : (dmatx_q & ~dma_eot_i);
    // Writing 1 starts a flush; writing while one runs, or writing 0, does nothing
    assign flush_start[IGC_PATH_TX] = wr_ctrl & ctrl_wd[IGC_TXF_BIT] & ~busy[IGC_PATH_TX];
    assign flush_start[IGC_PATH_RX] = wr_ctrl & ctrl_wd[IGC_RXF_BIT] & ~busy[IGC_PATH_RX];

    // Flushes never touch these fields, so the configuration survives them
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            speed_q <= IGC_SPEED_RST;
            gcm_q   <= IGC_GCM_RST;
            dmatx_q <= IGC_DMATX_RST;
        end else begin
            speed_q <= speed_d;
            gcm_q   <= gcm_d;
            dmatx_q <= dmatx_d;
        end
    end

    // Link clock: two flops, then a third for edge finding
    logic                 lk_s1_q;
    logic                 lk_s2_q;
    logic                 lk_s3_q;
    logic                 link_rise;

    assign link_rise = lk_s2_q & ~lk_s3_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lk_s1_q <= 1'b0;
            lk_s2_q <= 1'b0;
            lk_s3_q <= 1'b0;
        end else begin
            lk_s1_q <= i2c_clk_i;
            lk_s2_q <= lk_s1_q;
            lk_s3_q <= lk_s2_q;
        end
    end

    // One flush sequencer per path; each drives only its own flush line
    genvar gi;
    generate
        for (gi = 0; gi < IGC_NPATH; gi++) begin : g_flush
            logic                 busy_q;
            logic [IGC_CNT_W-1:0] edge_q;
            logic [IGC_CNT_W-1:0] tmo_q;
            logic                 edge_last;
            logic                 tmo_last;

            // Two link edges let the link-side logic see the flush; the timeout
            // covers a link clock that stands still between frames
            assign edge_last      = link_rise & (edge_q == IGC_FL_EDGES_LAST);
            assign tmo_last       = (tmo_q == IGC_FL_TMO_LAST);
            assign flush_done[gi] = busy_q & (edge_last | tmo_last);
            assign busy[gi]       = busy_q;

            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    busy_q <= 1'b0;
                    edge_q <= '0;
                    tmo_q  <= '0;
                end else if (flush_start[gi]) begin
                    busy_q <= 1'b1;
                    edge_q <= '0;
                    tmo_q  <= '0;
                end else if (flush_done[gi]) begin
                    busy_q <= 1'b0;
                end else if (busy_q) begin
                    edge_q <= link_rise ? edge_q + 1'b1 : edge_q;
                    tmo_q  <= tmo_q + 1'b1;
                end
            end
        end
    endgenerate

    assign transmit_flush_o = busy[IGC_PATH_TX];
    assign receive_flush_o  = busy[IGC_PATH_RX];

    // Bit-rate divider; reserved codes fall back to standard rate
    logic [IGC_DIV_W-1:0] div_q;
    logic [IGC_DIV_W-1:0] div_last;
    logic                 is_fast;
    logic                 div_wrap;

    assign is_fast  = (speed_q == IGC_SPEED_FAST);
    assign div_last = is_fast ? IGC_DIV_FAST_LAST : IGC_DIV_STD_LAST;
    assign div_wrap = (div_q >= div_last);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_q       <= '0;
            bit_tick_o  <= 1'b0;
            fast_mode_o <= 1'b0;
        end else begin
            div_q       <= div_wrap ? '0 : div_q + 1'b1;
            bit_tick_o  <= div_wrap;
            fast_mode_o <= is_fast;
        end
    end

    assign bus_speed_select_o = speed_q;

    // General call routing
    logic                 gc_direct;
    logic                 rx_open;
    logic                 push_d;
    logic                 act_d;

    // Only a software general call in mode 1 bypasses the FIFO
    assign gc_direct = rx_gcall_i & ~rx_gcall_hw_i & gcm_q;
    assign rx_open   = rx_valid_i & ~busy[IGC_PATH_RX];
    assign push_d    = rx_open & ~gc_direct;
    assign act_d     = rx_open & gc_direct;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_push_o      <= 1'b0;
            rx_data_o      <= 8'h00;
            gcall_action_o <= 1'b0;
            gcall_code_o   <= IGC_STATUS_RST;
        end else begin
            rx_push_o      <= push_d;
            rx_data_o      <= push_d ? rx_byte_i : rx_data_o;
            gcall_action_o <= act_d;
            gcall_code_o   <= act_d ? rx_byte_i : gcall_code_o;
        end
    end

    // DMA transmit interface
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dma_tx_run_o <= 1'b0;
            dma_tx_req_o <= 1'b0;
        end else begin
            dma_tx_run_o <= dmatx_d;
            dma_tx_req_o <= dmatx_q & tx_space_i & ~busy[IGC_PATH_TX];
        end
    end

    // Interrupt status, mask and output
    logic [IGC_IRQ_W-1:0] ist_q;
    logic [IGC_IRQ_W-1:0] msk_q;
    logic [IGC_IRQ_W-1:0] ev;
    logic [IGC_IRQ_W-1:0] ist_clr;
    logic [IGC_IRQ_W-1:0] ist_d;

    assign ev      = {dmatx_q & dma_eot_i, act_d, flush_done[IGC_PATH_RX],
                      flush_done[IGC_PATH_TX]};
    assign ist_clr = (wr_go & sel_irqs & avs_byteenable_i[0]) ?
                     avs_writedata_i[IGC_IRQ_W-1:0] : '0;
    // A new event wins over a clear in the same cycle
    assign ist_d   = (ist_q & ~ist_clr) | ev;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ist_q <= IGC_IRQ_RST;
            msk_q <= IGC_IRQ_RST;
            irq_o <= 1'b0;
        end else begin
            ist_q <= ist_d;
            if (wr_go & sel_mask & avs_byteenable_i[0]) begin
                msk_q <= avs_writedata_i[IGC_IRQ_W-1:0];
            end
            irq_o <= |(ist_d & msk_q);
        end
    end

    // Read data is captured in the wait cycle and holds through the completing edge
    logic [31:0]          rd_mux;

    assign rd_mux = sel_ctrl ? ctrl_rd :
                    sel_stat ? {24'h000000, gcall_code_o} :
                    sel_irqs ? {28'h0000000, ist_q} :
                    sel_mask ? {28'h0000000, msk_q} : 32'h00000000;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_q <= 32'h00000000;
        end else if (rd_take) begin
            rdata_q <= rd_mux;
        end
    end

    assign avs_readdata_o    = rdata_q;
    assign avs_waitrequest_o = wait_q;

    // Checks
    speed_fast_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (speed_q == IGC_SPEED_FAST) ##1 (speed_q == IGC_SPEED_FAST) |=> fast_mode_o)
        else $error("fast code did not select fast mode");
    speed_std_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (speed_q == IGC_SPEED_STD) |=> !fast_mode_o)
        else $error("standard code selected fast mode");
    gcm_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_ctrl && avs_byteenable_i[0]) |=> (gcm_q == $past(avs_writedata_i[IGC_GCM_BIT])))
        else $error("general call mode bit not written");
    hw_gcall_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (rx_valid_i && rx_gcall_i && rx_gcall_hw_i && !busy[IGC_PATH_RX])
        |=> rx_push_o && !gcall_action_o)
        else $error("hardware general call not passed to FIFO");
    gc_transp_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (rx_valid_i && rx_gcall_i && !gcm_q && !busy[IGC_PATH_RX])
        |=> rx_push_o && (rx_data_o == $past(rx_byte_i)))
        else $error("transparent general call lost");
    gc_direct_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (rx_valid_i && rx_gcall_i && !rx_gcall_hw_i && gcm_q && !busy[IGC_PATH_RX])
        |=> gcall_action_o)
        else $error("direct general call not executed");
    gc_nodata_a: assert property (@(posedge clk_i) disable iff (rst_i)
        gcall_action_o |-> !rx_push_o && (gcall_code_o == $past(rx_byte_i)))
        else $error("direct general call stored data");
    // A flush write may carry new settings; they must land as written, untouched by the flush
    tx_flush_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (flush_start[IGC_PATH_TX] && avs_byteenable_i[0])
        |=> transmit_flush_o
            && (speed_q == $past(avs_writedata_i[IGC_SPEED_MSB:IGC_SPEED_LSB]))
            && (gcm_q == $past(avs_writedata_i[IGC_GCM_BIT])))
        else $error("transmit flush not started or config changed");
    rx_flush_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (rx_valid_i && busy[IGC_PATH_RX]) |=> !rx_push_o)
        else $error("receive push during receive flush");
    flush_end_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(busy[IGC_PATH_TX]) |-> ##[2:65] !busy[IGC_PATH_TX])
        else $error("transmit flush did not self-clear");
    rx_flush_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(busy[IGC_PATH_RX]) |-> ##[2:65] !busy[IGC_PATH_RX])
        else $error("receive flush did not self-clear");
    dma_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !dmatx_q |=> !dma_tx_req_o)
        else $error("DMA request while disabled");
    dma_eot_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (dmatx_q && dma_eot_i && !wr_ctrl) |=> !dmatx_q ##1 !dma_tx_req_o)
        else $error("end of transfer did not clear enable");
    flush_iso_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (flush_start[IGC_PATH_TX] && !busy[IGC_PATH_RX] && !flush_start[IGC_PATH_RX])
        |=> !receive_flush_o)
        else $error("transmit flush disturbed receive path");

endmodule : igc_ctrl

`default_nettype wire

/* sim/igc_far_model.sv */
// Far side of the node: link clock of the serial bus, received bytes, tx space and DMA strobes.
// Assumes the bench calls its tasks from a process that follows clk_i.
`timescale 1ns/1ns
`default_nettype none

module igc_far_model (
    input  wire logic       clk_i,          // System clock
    output logic            i2c_clk_o,      // Link clock, still outside frames
    output logic            rx_valid_o,     // Received byte strobe
    output logic [7:0]      rx_byte_o,      // Received byte
    output logic            rx_gcall_o,     // General call qualifier
    output logic            rx_gcall_hw_o,  // Hardware general call qualifier
    output logic            tx_space_o,     // Tx FIFO space
    output logic            dma_eot_o       // DMA end of transfer
);
    logic frame_q;

    // Odd offset keeps link edges clear of system clock edges
    initial begin
        {i2c_clk_o, rx_valid_o, rx_byte_o, rx_gcall_o, rx_gcall_hw_o, dma_eot_o} = '0;
        frame_q    = 1'b0;
        tx_space_o = 1'b1;
        #7;
        forever begin
            #160;
            if (frame_q) i2c_clk_o = ~i2c_clk_o;
        end
    end

    task automatic frame(input logic on);
        frame_q = on;
    endtask : frame

    // Byte lane shows the inverse once released, never the stale value
    task automatic send(input logic [7:0] b, input logic gc, input logic hw);
        @(posedge clk_i);
        rx_valid_o    <= 1'b1;
        rx_byte_o     <= b;
        rx_gcall_o    <= gc;
        rx_gcall_hw_o <= hw;
        @(posedge clk_i);
        rx_valid_o    <= 1'b0;
        rx_byte_o     <= ~b;
        rx_gcall_o    <= 1'b0;
        rx_gcall_hw_o <= 1'b0;
    endtask : send

    task automatic eot;
        @(posedge clk_i);
        dma_eot_o <= 1'b1;
        @(posedge clk_i);
        dma_eot_o <= 1'b0;
    endtask : eot
endmodule : igc_far_model
`default_nettype wire

/* sim/igc_ctrl_bench.sv */
// Self-checking bench of the control, flush and general-call block.
// Assumes igc_pkg and igc_ctrl compiled first, and the far-side model beside it.
`timescale 1ns/1ns
`default_nettype none

module igc_ctrl_bench;
    import igc_pkg::*;
    logic        clk_i, rst_i, avs_read_i, avs_write_i, avs_waitrequest_o, irq_o;
    logic [3:0]  avs_address_i, avs_byteenable_i;
    logic [31:0] avs_writedata_i, avs_readdata_o, q;
    logic        i2c_clk_i, bit_tick_o, fast_mode_o, transmit_flush_o, receive_flush_o;
    logic [1:0]  bus_speed_select_o;
    logic        rx_valid_i, rx_gcall_i, rx_gcall_hw_i, rx_push_o, gcall_action_o;
    logic [7:0]  rx_byte_i, rx_data_o, gcall_code_o;
    logic        tx_space_i, dma_eot_i, dma_tx_run_o, dma_tx_req_o;
    int          mismatches, total_checks, g, n;
    logic [31:0] cfg;

    igc_ctrl dut (.clk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
        .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .irq_o, .i2c_clk_i, .bit_tick_o,
        .bus_speed_select_o, .fast_mode_o, .transmit_flush_o, .receive_flush_o, .rx_valid_i,
        .rx_byte_i, .rx_gcall_i, .rx_gcall_hw_i, .rx_push_o, .rx_data_o, .gcall_action_o,
        .gcall_code_o, .tx_space_i, .dma_eot_i, .dma_tx_run_o, .dma_tx_req_o);

    igc_far_model far (.clk_i, .i2c_clk_o(i2c_clk_i), .rx_valid_o(rx_valid_i),
        .rx_byte_o(rx_byte_i), .rx_gcall_o(rx_gcall_i), .rx_gcall_hw_o(rx_gcall_hw_i),
        .tx_space_o(tx_space_i), .dma_eot_o(dma_eot_i));

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Request held until the edge that samples waitrequest low
    task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        avs_address_i   <= a;
        avs_writedata_i <= d;
        avs_write_i     <= w;
        avs_read_i      <= ~w;
        do begin
            @(posedge clk_i);
            k++;
        end while (avs_waitrequest_o !== 1'b0 && k < 20);
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i  <= 1'b0;
        chk("waitrequest", 32'h0, 32'(avs_waitrequest_o));
    endtask : acc

    task automatic rdc(input string what, input logic [3:0] a, input logic [31:0] exp);
        acc(1'b0, a, 32'h0);
        chk(what, exp, q);
    endtask : rdc

    task automatic gap(output int c);
        repeat (3) begin
            c = 0;
            do begin
                @(posedge clk_i);
                c++;
            end while (bit_tick_o !== 1'b1 && c < 600);
        end
    endtask : gap

    task automatic gcase(input logic m, input logic hw, input logic [7:0] b);
        acc(1'b1, IGC_OFS_CTRL, 32'(m) << IGC_GCM_BIT);
        far.send(b, 1'b1, hw);
        @(posedge clk_i);
        chk("rx push", 32'(!(m && !hw)), 32'(rx_push_o));
        chk("gcall action", 32'(m && !hw), 32'(gcall_action_o));
        if (m && !hw) begin
            chk("gcall code", 32'(b), 32'(gcall_code_o));
            rdc("status code", IGC_OFS_STATUS, 32'(b));
        end else begin
            chk("rx data", 32'(b), 32'(rx_data_o));
        end
    endtask : gcase

    // Software side polls the control word only, never the FIFOs
    task automatic poll(input int b);
        n = 0;
        do begin
            acc(1'b0, IGC_OFS_CTRL, 32'h0);
            n++;
        end while (q[b] !== 1'b0 && n < 60);
        chk("flush self clear", 32'h0, 32'(q[b]));
        chk("flush seen busy", 32'h1, 32'(n > 1));
    endtask : poll

    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        #800000;
        mismatches++;
        finish_test();
    end

    initial begin
        {avs_read_i, avs_write_i, avs_address_i, avs_writedata_i} = '0;
        avs_byteenable_i = 4'hF;
        rst_i = 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc("ctrl reset", IGC_OFS_CTRL, 32'h0);
        rdc("status reset", IGC_OFS_STATUS, 32'h0);
        chk("dma run idle", 32'h0, 32'(dma_tx_run_o));
        chk("dma req idle", 32'h0, 32'(dma_tx_req_o));
        acc(1'b1, 4'h2, 32'hFFFF);
        rdc("unmapped", 4'h2, 32'h0);
        rdc("ctrl kept", IGC_OFS_CTRL, 32'h0);
        $display("test reset done");
        for (int i = 1; i < 4; i++) begin
            acc(1'b1, IGC_OFS_CTRL, 32'(i % 3) << IGC_SPEED_LSB);
            gap(g);
            chk("speed out", 32'(i % 3), 32'(bus_speed_select_o));
            chk("fast mode", 32'(i % 3 == 1), 32'(fast_mode_o));
            chk("bit period", (i % 3 == 1) ? IGC_BIT_CYC_FAST : IGC_BIT_CYC_STD, g);
        end
        $display("test speed done");
        gcase(1'b0, 1'b0, 8'h5A);
        gcase(1'b1, 1'b1, 8'hC3);
        gcase(1'b1, 1'b0, 8'h96);
        $display("test gcall done");
        acc(1'b1, IGC_OFS_CTRL, 32'h200);
        @(posedge clk_i);
        chk("dma run", 32'h1, 32'(dma_tx_run_o));
        @(posedge clk_i);
        chk("dma req", 32'h1, 32'(dma_tx_req_o));
        far.eot();
        @(posedge clk_i);
        chk("dma run off", 32'h0, 32'(dma_tx_run_o));
        rdc("ctrl dma clear", IGC_OFS_CTRL, 32'h0);
        rdc("irq status", IGC_OFS_IRQ_ST, 32'hC);
        acc(1'b1, IGC_OFS_IRQ_ST, 32'hF);
        rdc("irq cleared", IGC_OFS_IRQ_ST, 32'h0);
        acc(1'b1, IGC_OFS_IRQ_MSK, 32'h1);
        rdc("irq mask", IGC_OFS_IRQ_MSK, 32'h1);
        $display("test dma done");
        cfg = 32'h250;
        acc(1'b1, IGC_OFS_CTRL, cfg);
        far.frame(1'b1);
        acc(1'b1, IGC_OFS_CTRL, cfg | 32'h80);
        @(posedge clk_i);
        chk("tx flush", 32'h1, 32'(transmit_flush_o));
        chk("rx untouched", 32'h0, 32'(receive_flush_o));
        // Request flop sees the flush one cycle late
        @(posedge clk_i);
        chk("dma req held", 32'h0, 32'(dma_tx_req_o));
        far.send(8'hA5, 1'b0, 1'b0);
        @(posedge clk_i);
        chk("rx during tx flush", 32'h1, 32'(rx_push_o));
        poll(IGC_TXF_BIT);
        far.frame(1'b0);
        rdc("cfg after tx flush", IGC_OFS_CTRL, cfg);
        chk("irq raised", 32'h1, 32'(irq_o));
        $display("test tx flush done");
        acc(1'b1, IGC_OFS_CTRL, cfg | 32'h100);
        @(posedge clk_i);
        chk("rx flush", 32'h1, 32'(receive_flush_o));
        chk("tx untouched", 32'h0, 32'(transmit_flush_o));
        far.send(8'h3C, 1'b0, 1'b0);
        @(posedge clk_i);
        chk("rx push held", 32'h0, 32'(rx_push_o));
        chk("dma during rx flush", 32'h1, 32'(dma_tx_req_o));
        poll(IGC_RXF_BIT);
        rdc("cfg after rx flush", IGC_OFS_CTRL, cfg);
        rdc("irq both flushes", IGC_OFS_IRQ_ST, 32'h3);
        acc(1'b1, IGC_OFS_IRQ_ST, 32'h1);
        repeat (2) @(posedge clk_i);
        chk("irq masked off", 32'h0, 32'(irq_o));
        rdc("irq rx left", IGC_OFS_IRQ_ST, 32'h2);
        $display("test rx flush done");
        finish_test();
    end
endmodule : igc_ctrl_bench
`default_nettype wire
